// *** sarseq_pkg.sv ***
`default_nettype none
package sarseq_pkg;

	// converter width and split between slow and fast trial groups
	localparam int RES_BITS  = 8;
	localparam int MSB_GROUP = 4;

	// timing figures in their own units
	localparam int MCLK_PERIOD_NS = 100;
	localparam int MSB_TRIAL_NS   = 160;
	localparam int LSB_TRIAL_NS   = 80;

	// a trial period is a least time: round up, never below one cycle
	localparam int LSB_CYC_RAW = (LSB_TRIAL_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int LSB_CYC     = (LSB_CYC_RAW < 1) ? 1 : LSB_CYC_RAW;
	// slow trials run on the halved timing clock
	localparam int MSB_CYC     = 2 * LSB_CYC;

	localparam int DWELL_W = 4;

	// code loaded by the clear pulse: top bit on, all others off
	localparam logic [RES_BITS-1:0] INIT_CODE = 8'h80;
	// token position at clear: the top bit is under trial
	localparam logic [RES_BITS-1:0] TOK_INIT  = 8'h80;
	localparam logic [RES_BITS-1:0] TOK_NONE  = 8'h00;

	// converter control states
	typedef enum logic [1:0] {
		SARSEQ_IDLE,
		SARSEQ_CLEAR,
		SARSEQ_TRIAL
	} sarseq_state_t;

	// finished answer handed to the system
	typedef struct packed {
		logic                eoc;
		logic [RES_BITS-1:0] data;
	} sarseq_result_t;

endpackage : sarseq_pkg
`default_nettype wire

// *** sarseq_bit_cell.sv ***
`default_nettype none
// one result flip-flop: preset by clear, set by its own trial start,
// clocked with the decision only when its own trial ends
module sarseq_bit_cell #(
	parameter logic INIT = 1'b0
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// control
	input  wire logic preset,
	input  wire logic set_trial,
	input  wire logic capture,
	input  wire logic decision,
	// state
	output var  logic q
);

	// clear has priority, then trial start, then capture; else hold
	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= 1'b0;
		end else if (preset) begin
			q <= INIT;
		end else if (set_trial) begin
			q <= 1'b1;
		end else if (capture) begin
			q <= decision;
		end
	end

endmodule : sarseq_bit_cell
`default_nettype wire

// *** sarseq_top.sv ***
`default_nettype none
// How it works
// - start is sampled high on a clock edge to begin a conversion.
// - right after acceptance an active-low clear pulse is issued.
// - clear sets the top result bit, clears the rest and puts the timing token on the top bit.
// - first trial is half scale; second trial adds the quarter-scale bit.
// - every result bit sees the decision, taking it only on its capture edge.
// - clear pulse is high again before the first timing shift.
// - top-group token moves only on half-rate ticks; each move sets the next bit.
// - setting a bit starts its trial and captures the previous decision.
// - bits neither set nor captured hold their values.
// - bits tried from first to eighth; end flag rises after the last capture.
// - four top bits get 200 ns each (the top one also the clear cycle), four low bits 100 ns each.
// - timing comes from a token on a fast clock and its halved copy.
module sarseq_top
	import sarseq_pkg::*;
#(
	parameter int N_BITS = RES_BITS
) (
	// clock and reset
	input  wire logic                mclk,
	input  wire logic                rst,
	// conversion request, asynchronous
	input  wire logic                start,
	// comparator decision on the code now driven
	input  wire logic                comp_in,
	// drive to the current-output converter
	output var  logic [N_BITS-1:0]   dac_code,
	// clear and reset pulse, active low
	output var  logic                clear_n,
	// answer and end-of-conversion
	output var  sarseq_result_t      conv_out
);

	sarseq_state_t       st;
	logic                start_m;
	logic                start_s;
	logic [N_BITS-1:0]   tok;
	logic [N_BITS:0]     tok_up;
	logic [DWELL_W-1:0]  dwell;
	logic                half_rate_timing_clock;
	logic                fast_timing_clock;
	logic                msb_grp;
	logic                adv;
	logic                last;
	logic                accept;
	logic                eoc_flag;
	logic [N_BITS-1:0]   answer;

	// start arrives from outside the clock domain
	always_ff @(posedge mclk) begin
		if (rst) begin
			start_m <= 1'b0;
			start_s <= 1'b0;
		end else begin
			start_m <= start;
			start_s <= start_m;
		end
	end

	// the decision judges our own registered code, so it is timed by mclk;
	// two flops here would hand each capture the previous trial's answer

	// start counts only when idle, so a mid-run request is dropped
	assign accept = (st == SARSEQ_IDLE) && start_s;

	// fast tick every lsb period; slow group also needs the half-rate phase
	assign fast_timing_clock = (dwell == DWELL_W'(LSB_CYC - 1));
	assign msb_grp           = |tok[N_BITS-1:N_BITS-MSB_GROUP];
	assign adv               = (st == SARSEQ_TRIAL) && fast_timing_clock
	                           && (!msb_grp || half_rate_timing_clock);
	assign last              = tok[0];

	// control sequence: idle, one clear cycle, then trials
	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= SARSEQ_IDLE;
		end else begin
			unique case (st)
				SARSEQ_IDLE: begin
					if (accept) begin
						st <= SARSEQ_CLEAR;
					end
				end
				SARSEQ_CLEAR: begin
					st <= SARSEQ_TRIAL;
				end
				SARSEQ_TRIAL: begin
					if (adv && last) begin
						st <= SARSEQ_IDLE;
					end
				end
				default: begin
					st <= SARSEQ_IDLE;
				end
			endcase
		end
	end

	// clear pulse low for exactly the clear cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			clear_n <= 1'b1;
		end else begin
			clear_n <= !accept;
		end
	end

	// one-hot token stands for the two shift registers; clear leaves top bit
	always_ff @(posedge mclk) begin
		if (rst) begin
			tok <= TOK_NONE;
		end else if (accept) begin
			tok <= TOK_INIT;
		end else if (adv) begin
			tok <= tok >> 1;
		end
	end

	// fast timing divider and halved copy, both restarted by clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			dwell                  <= '0;
			half_rate_timing_clock <= 1'b0;
		end else if (st != SARSEQ_TRIAL) begin
			dwell                  <= '0;
			half_rate_timing_clock <= 1'b0;
		end else if (fast_timing_clock) begin
			dwell                  <= '0;
			half_rate_timing_clock <= !half_rate_timing_clock;
		end else begin
			dwell <= dwell + DWELL_W'(1);
		end
	end

	// token widened by one so the top cell's set input reads a plain zero
	assign tok_up = {1'b0, tok};

	// result cells: one flip-flop per bit, set when the token reaches it
	genvar gi;
	generate
		for (gi = 0; gi < N_BITS; gi++) begin : g_bit
			sarseq_bit_cell #(
				.INIT      (INIT_CODE[gi])
			) i_sarseq_bit_cell (
				.mclk      (mclk),
				.rst       (rst),
				.preset    (accept),
				.set_trial (adv && tok_up[gi+1]),
				.capture   (adv && tok[gi]),
				.decision  (comp_in),
				.q         (dac_code[gi])
			);
		end
	endgenerate

	// answer held separately so it stays steady through the next clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			answer <= '0;
		end else if (adv && last) begin
			answer <= {dac_code[N_BITS-1:1], comp_in};
		end
	end

	// end flag: low from reset, up after last capture, down on next accept
	always_ff @(posedge mclk) begin
		if (rst) begin
			eoc_flag <= 1'b0;
		end else if (adv && last) begin
			eoc_flag <= 1'b1;
		end else if (accept) begin
			eoc_flag <= 1'b0;
		end
	end

	// one driver for the whole result word, both fields straight from flops
	assign conv_out = '{eoc: eoc_flag, data: answer};

	// checks, all in the single clock domain
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	AST_START_ACCEPT: assert property (
		(st == SARSEQ_IDLE && start_s) |=> (st == SARSEQ_CLEAR)
	) else $error("start not accepted while idle");

	AST_CLEAR_INIT: assert property (
		(st == SARSEQ_CLEAR) |-> (!clear_n && dac_code == INIT_CODE && tok == TOK_INIT)
	) else $error("clear cycle without half-scale code");

	AST_CLEAR_RELEASE: assert property (
		(st == SARSEQ_CLEAR) |=> (clear_n && st == SARSEQ_TRIAL && !adv)
	) else $error("clear still low at first trial cycle");

	AST_SECOND_TRIAL: assert property (
		(st == SARSEQ_CLEAR) |=> ##1 adv ##1 dac_code[N_BITS-2]
	) else $error("second trial bit not set after first slow trial");

	AST_DECISION: assert property (
		adv |=> ((dac_code & $past(tok)) == ($past(comp_in) ? $past(tok) : TOK_NONE))
	) else $error("decision not captured into trial bit");

	AST_NEXT_SET: assert property (
		(adv && !last) |=> ((dac_code & tok) == tok)
	) else $error("next trial bit not set on advance");

	AST_HOLD: assert property (
		(st == SARSEQ_TRIAL && !adv) |=> $stable(dac_code)
	) else $error("result bits moved without capture");

	AST_SLOW_DWELL: assert property (
		(adv && |tok[N_BITS-1:N_BITS-MSB_GROUP+1]) |=> !adv ##1 adv
	) else $error("slow trial not two cycles");

	AST_FAST_DWELL: assert property (
		(adv && |tok[N_BITS-MSB_GROUP:1]) |=> adv
	) else $error("fast trial not one cycle");

	AST_EOC: assert property (
		(adv && last) |=> (conv_out.eoc && conv_out.data == dac_code && st == SARSEQ_IDLE)
	) else $error("end flag or answer wrong after last capture");

	AST_EOC_CAUSE: assert property (
		$rose(conv_out.eoc) |-> $past(adv && last)
	) else $error("end flag rose without a finished conversion");

	AST_IGNORE_START: assert property (
		(st == SARSEQ_TRIAL && start_s) |=> (clear_n && st != SARSEQ_CLEAR)
	) else $error("start honoured during a conversion");

	AST_HALF_RATE: assert property (
		(st == SARSEQ_TRIAL && fast_timing_clock) |=>
			(half_rate_timing_clock != $past(half_rate_timing_clock))
	) else $error("half-rate clock did not toggle");

	COV_CONVERSION: cover property ($rose(conv_out.eoc));
	COV_CONTINUOUS: cover property (conv_out.eoc && start_s ##1 st == SARSEQ_CLEAR);
	COV_FULL_SCALE: cover property ($rose(conv_out.eoc) && conv_out.data == 8'hFF);

endmodule : sarseq_top
`default_nettype wire

// *** sarseq_adc_model.sv ***
`default_nettype none
// converter and comparator seen from the sequencer pins
module sarseq_adc_model
	import sarseq_pkg::*;
(
	// converter drive and analog level
	input  wire logic [RES_BITS-1:0] dac_code,
	input  wire logic [RES_BITS-1:0] vin,
	// decision back to the sequencer
	output var  logic                comp_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// ideal and instant: at-or-above reads high, so the answer equals vin
	always_comb begin
		comp_in = (vin >= dac_code);
	end
endmodule : sarseq_adc_model
`default_nettype wire

// *** sarseq_top_bench.sv ***
`default_nettype none
module sarseq_top_bench
	import sarseq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                mclk;
	logic                rst;
	logic                start;
	logic                comp_in;
	logic                clear_n;
	logic [RES_BITS-1:0] dac_code;
	logic [RES_BITS-1:0] vin;
	logic [RES_BITS-1:0] held;
	logic [RES_BITS-1:0] last;
	sarseq_result_t      conv_out;
	int                  failures;
	int                  checks_done;

	sarseq_top i_sarseq_top (
		.mclk(mclk), .rst(rst), .start(start), .comp_in(comp_in),
		.dac_code(dac_code), .clear_n(clear_n), .conv_out(conv_out)
	);
	sarseq_adc_model i_sarseq_adc_model (.dac_code(dac_code), .vin(vin), .comp_in(comp_in));

	// 10 MHz clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// system output register on the clear pulse rising edge
	always @(posedge clear_n) held <= conv_out.data;

	task final_report();
		if (failures == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	task check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// inputs move and outputs are read 1 ns after the edge
	task step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step

	task reset_chk();
		check(dac_code, 8'h00);
		check(8'(clear_n), 8'h01);
		check(8'(conv_out.eoc), 8'h00);
		check(conv_out.data, 8'h00);
	endtask : reset_chk

	// one conversion; cont keeps start high, as when eoc feeds start
	task convert(input logic [7:0] v, input logic cont);
		int n;
		vin = v;
		start = 1'b1;
		n = 0;
		while (clear_n !== 1'b0 && n < 8) begin
			step(1);
			n++;
		end
		check(8'(n < 8), 8'h01);
		check(dac_code, INIT_CODE);
		check(8'(conv_out.eoc), 8'h00);
		if (!cont)
			start = 1'b0;
		step(1);
		check(8'(clear_n), 8'h01);
		check(held, last);
		step(2);
		check(8'(dac_code[7:6]), 8'({v[7], 1'b1}));
		n = 3;
		// start still high here must not restart the run
		while (conv_out.eoc !== 1'b1 && n < 20) begin
			step(1);
			n++;
		end
		check(8'(n), 8'h0D);
		check(conv_out.data, v);
		last = v;
	endtask : convert

	initial begin
		rst = 1'b1;
		start = 1'b0;
		vin = 8'h00;
		last = 8'h00;
		failures = 0;
		checks_done = 0;
		step(10);
		reset_chk();
		rst = 1'b0;
		step(2);
		convert(8'hA5, 1'b0);
		step(3);
		convert(8'h00, 1'b0);
		step(3);
		convert(8'hFF, 1'b0);
		// reset in mid-conversion
		start = 1'b1;
		step(6);
		rst = 1'b1;
		start = 1'b0;
		step(2);
		reset_chk();
		rst = 1'b0;
		last = 8'h00;
		step(2);
		// continuous runs back to back
		convert(8'h5A, 1'b1);
		convert(8'h80, 1'b1);
		convert(8'h7F, 1'b0);
		final_report();
	end

	// hang guard, far beyond the roughly 12 microseconds needed
	initial begin
		#100000;
		failures++;
		final_report();
	end
endmodule : sarseq_top_bench
`default_nettype wire
